// ===== core/rasd_return_stack.v
/*
 * Four-level return-address stack with its pointer/interrupt-enable register
 * and eight slot byte registers on a plain register port. A push saves the
 * program counter into the slot named by the inverted pointer; a pop hands
 * the newest saved value back one cycle later on pop_pc_o.
 * Assumes push and pop requests come from the core sequencer on clk_sys_i,
 * one cycle each; register strobes are one cycle, never both at once.
 * Assumes the sequencer never pushes and pops in one cycle on purpose; if it
 * does, the push is kept and the pop is dropped.
 * No overflow or underflow flag exists: the pointer wraps modulo four and
 * firmware is expected to keep its own call depth in check.
 * Register reads have no side effects; a pop is the only way to consume
 * a slot.
 */
`timescale 1ns/1ps
`include "rasd_defs.vh"

module rasd_return_stack (
    input  wire                        clk_sys_i,           // Core clock, 250 MHz
    input  wire                        arst_n_i,            // Async reset, active low
    input  wire                        push_i,              // Call or interrupt entry, one-cycle pulse
    input  wire [`RASD_PC_W-1:0]       push_pc_i,           // Program counter to save
    input  wire                        ret_sub_i,           // Return from subroutine, pulse
    input  wire                        ret_irq_i,           // Return from interrupt, pulse
    output reg  [`RASD_PC_W-1:0]       pop_pc_o,            // Restored program counter
    output reg                         pop_valid_o,         // Restored value valid, pulse
    output wire [`RASD_PTR_W-1:0]      stack_level_pointer_o, // Current level pointer
    output wire                        global_irq_enable_o, // Interrupt enable level
    input  wire [`RASD_ADDR_W-1:0]     reg_addr_i,          // Register address
    input  wire [`RASD_DATA_W-1:0]     reg_wdata_i,         // Register write data
    input  wire                        reg_we_i,            // Write strobe
    input  wire                        reg_re_i,            // Read strobe
    output reg  [`RASD_DATA_W-1:0]     reg_rdata_o          // Read data, cycle after strobe
);

    // ****************************************************************
    // Address decode helpers
    // ****************************************************************
    // bank 0 slot window
    function slot_hit;
        input [`RASD_ADDR_W-1:0] addr;
        begin
            slot_hit = (addr >= `RASD_ADDR_SLOT_LO) && (addr <= `RASD_ADDR_SLOT_END);
        end
    endfunction

    function [`RASD_PTR_W-1:0] slot_index;
        input [`RASD_ADDR_W-1:0] addr;
        reg   [`RASD_ADDR_W-1:0] rel;
        begin
            rel        = addr - `RASD_ADDR_SLOT_LO;
            slot_index = rel[`RASD_PTR_W:1];
        end
    endfunction

    // Odd offsets in the window are the high bytes
    function slot_is_high;
        input [`RASD_ADDR_W-1:0] addr;
        begin
            slot_is_high = addr[0];
        end
    endfunction

    // One-hot select of a slot index, shared by the push and register paths
    function [`RASD_DEPTH-1:0] slot_onehot;
        input [`RASD_PTR_W-1:0] idx;
        integer k;
        begin
            for (k = 0; k < `RASD_DEPTH; k = k + 1) begin
                slot_onehot[k] = (idx == k[`RASD_PTR_W-1:0]);
            end
        end
    endfunction

    // One pointer step: pushes move down and pops move up, both modulo four
    function [`RASD_PTR_W-1:0] ptr_step;
        input [`RASD_PTR_W-1:0] ptr;
        input                   up;
        begin
            if (up) begin
                ptr_step = ptr + {{(`RASD_PTR_W-1){1'b0}}, 1'b1};
            end else begin
                ptr_step = ptr - {{(`RASD_PTR_W-1){1'b0}}, 1'b1};
            end
        end
    endfunction

    // Image of the pointer register as software reads it; unused bits read zero
    function [`RASD_DATA_W-1:0] ptr_image;
        input                   global_irq_enable;
        input [`RASD_PTR_W-1:0] ptr;
        begin
            ptr_image                              = `RASD_RDATA_RESET;
            ptr_image[`RASD_GIE_BIT]               = global_irq_enable;
            ptr_image[`RASD_PTR_MSB:`RASD_PTR_LSB] = ptr;
        end
    endfunction

    // Byte of a saved address as seen on the register port
    function [`RASD_DATA_W-1:0] slot_image;
        input [`RASD_PC_W-1:0] pc;
        input                  high;
        begin
            slot_image = `RASD_RDATA_RESET;
            if (high) begin
                slot_image[`RASD_HI_W-1:0] = pc[`RASD_PC_HI_MSB:`RASD_PC_HI_LSB];
            end else begin
                slot_image = pc[`RASD_PC_LO_MSB:0];
            end
        end
    endfunction

    // ****************************************************************
    // Pointer and interrupt enable
    // ****************************************************************
    // two-bit pointer; the slots below are ten bits wide
    reg  [`RASD_PTR_W-1:0] level_ptr_reg;
    reg  [`RASD_PTR_W-1:0] level_ptr_next;
    reg                    global_irq_enable_reg;
    reg                    global_irq_enable_next;
    wire                   pop_req;
    reg                    do_push;
    reg                    do_pop;
    wire                   ptr_wr;
    wire [`RASD_PTR_W-1:0] push_slot;
    wire [`RASD_PTR_W-1:0] ptr_after_pop;
    wire [`RASD_PTR_W-1:0] pop_slot;

    assign pop_req = ret_sub_i | ret_irq_i;
    // A push and a pop together cannot both be honoured; the push is kept,
    // since dropping a call would lose a return address for good
    always @* begin
        do_push = 1'b0;
        do_pop  = 1'b0;
        case ({push_i, pop_req})
            2'h2: begin
                do_push = 1'b1;
            end
            2'h3: begin
                do_push = 1'b1;
            end
            2'h1: begin
                do_pop = 1'b1;
            end
            default: begin
                do_push = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Register write decode
    // ****************************************************************
    // pointer register in bank 0
    assign ptr_wr  = reg_we_i && (reg_addr_i == `RASD_ADDR_PTR);

    // slot index is the inverted pointer
    assign push_slot     = ~level_ptr_reg;
    assign ptr_after_pop = ptr_step(level_ptr_reg, 1'b1);
    assign pop_slot      = ~ptr_after_pop;

    // ****************************************************************
    // Slot selects
    // ****************************************************************
    wire                   slot_wr;
    wire [`RASD_DEPTH-1:0] sw_slot_dec;
    wire [`RASD_DEPTH-1:0] push_slot_dec;

    // software write into the slot window
    assign slot_wr       = reg_we_i && slot_hit(reg_addr_i);
    assign sw_slot_dec   = slot_onehot(slot_index(reg_addr_i));
    // push lands in the slot named by the inverted pointer
    assign push_slot_dec = slot_onehot(push_slot);

    // the enable bit follows software only; stack motion never touches it
    always @* begin
        global_irq_enable_next = global_irq_enable_reg;
        if (ptr_wr) begin
            global_irq_enable_next = reg_wdata_i[`RASD_GIE_BIT];
        end
    end

    always @* begin
        level_ptr_next = level_ptr_reg;
        if (ptr_wr) begin
            level_ptr_next = reg_wdata_i[`RASD_PTR_MSB:`RASD_PTR_LSB];
        end
        // Hardware stack motion wins over a software pointer write
        if (do_push) begin
            level_ptr_next = ptr_step(level_ptr_reg, 1'b0);
        end else if (do_pop) begin
            level_ptr_next = ptr_after_pop;
        end
    end

    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            level_ptr_reg         <= `RASD_PTR_RESET;
            global_irq_enable_reg <= `RASD_GIE_RESET;
        end else begin
            level_ptr_reg         <= level_ptr_next;
            global_irq_enable_reg <= global_irq_enable_next;
        end
    end

    assign stack_level_pointer_o = level_ptr_reg;
    assign global_irq_enable_o   = global_irq_enable_reg;

    // ****************************************************************
    // Return-address slots
    // ****************************************************************
    wire [`RASD_PC_W-1:0] slot_val [0:`RASD_DEPTH-1];

    genvar gi;
    generate
        for (gi = 0; gi < `RASD_DEPTH; gi = gi + 1) begin : g_slot
            reg  [`RASD_PC_W-1:0] slot_reg;
            reg  [`RASD_PC_W-1:0] slot_next;
            wire                  sw_sel;
            wire                  push_sel;
            wire                  lo_wr;
            wire                  hi_wr;

            assign sw_sel   = slot_wr && sw_slot_dec[gi];
            assign push_sel = do_push && push_slot_dec[gi];
            // odd offsets carry pc bits 9:8, even ones bits 7:0
            assign lo_wr    = sw_sel && !slot_is_high(reg_addr_i);
            assign hi_wr    = sw_sel && slot_is_high(reg_addr_i);

            always @* begin
                slot_next = slot_reg;
                if (hi_wr) begin
                    slot_next[`RASD_PC_HI_MSB:`RASD_PC_HI_LSB] = reg_wdata_i[`RASD_HI_W-1:0];
                end
                if (lo_wr) begin
                    slot_next[`RASD_PC_LO_MSB:0] = reg_wdata_i;
                end
                // A push into this slot beats a software write in the same cycle
                if (push_sel) begin
                    slot_next = push_pc_i;
                end
            end

            always @(posedge clk_sys_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    slot_reg <= `RASD_SLOT_RESET;
                end else begin
                    slot_reg <= slot_next;
                end
            end

            assign slot_val[gi] = slot_reg;
        end
    endgenerate

    // ****************************************************************
    // Restore path
    // ****************************************************************
    reg [`RASD_PC_W-1:0] pop_pc_next;

    // pop_pc_o holds between pops so the sequencer may sample it late;
    // a pop of an empty stack returns slot 3 as it stands
    always @* begin
        pop_pc_next = pop_pc_o;
        if (do_pop) begin
            pop_pc_next = slot_val[pop_slot];
        end
    end

    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pop_pc_o    <= `RASD_SLOT_RESET;
            pop_valid_o <= 1'b0;
        end else begin
            pop_valid_o <= do_pop;
            pop_pc_o    <= pop_pc_next;
        end
    end

    // ****************************************************************
    // Register read port
    // ****************************************************************
    reg [`RASD_DATA_W-1:0] rd_mux;
    reg [`RASD_PC_W-1:0]   rd_slot;
    reg                    rd_high;
    reg [`RASD_DATA_W-1:0] rdata_next;

    // Unmapped addresses read as zero, so the tail of the window is harmless;
    // the mux is built every cycle, only the strobe decides whether it lands
    always @* begin
        rd_mux  = `RASD_RDATA_RESET;
        rd_slot = slot_val[slot_index(reg_addr_i)];
        rd_high = slot_is_high(reg_addr_i);
        if (reg_addr_i == `RASD_ADDR_PTR) begin
            rd_mux = ptr_image(global_irq_enable_reg, level_ptr_reg);
        end else if (slot_hit(reg_addr_i)) begin
            rd_mux = slot_image(rd_slot, rd_high);
        end
    end

    // Read data stands only in the cycle after the strobe, zero otherwise,
    // so a master that samples a cycle late sees zero rather than stale data
    always @* begin
        rdata_next = `RASD_RDATA_RESET;
        if (reg_re_i) begin
            rdata_next = rd_mux;
        end
    end

    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= `RASD_RDATA_RESET;
        end else begin
            reg_rdata_o <= rdata_next;
        end
    end

endmodule // rasd_return_stack

// ===== core/rasd_defs.vh
/*
 * Constants of the return-address stack: register offsets, field positions,
 * reset values and widths.
 * Assumes it is included by bare name from the design files under core/.
 */
`ifndef RASD_DEFS_VH
`define RASD_DEFS_VH

// ****************************************************************
// Widths and depth
// ****************************************************************
`define RASD_PC_W          10
`define RASD_PTR_W         2
`define RASD_DEPTH         4
`define RASD_ADDR_W        8
`define RASD_DATA_W        8
`define RASD_HI_W          2

// ****************************************************************
// Register offsets
// ****************************************************************
`define RASD_ADDR_PTR      8'hDF
`define RASD_ADDR_SLOT_LO  8'hF0
`define RASD_ADDR_SLOT_END 8'hF7

// ****************************************************************
// Field positions
// ****************************************************************
`define RASD_GIE_BIT       7
`define RASD_PTR_MSB       1
`define RASD_PTR_LSB       0
`define RASD_PC_HI_MSB     9
`define RASD_PC_HI_LSB     8
`define RASD_PC_LO_MSB     7

// ****************************************************************
// Reset values
// ****************************************************************
`define RASD_PTR_RESET     2'h3
`define RASD_GIE_RESET     1'h0
`define RASD_SLOT_RESET    10'h000
`define RASD_RDATA_RESET   8'h00

`endif

// ===== test/rasd_seq_model.sv
/* Model of the core sequencer that pushes and pops the return stack.
   Assumes it is stepped by the bench one clock at a time on clk_sys_i. */
`timescale 1ns/1ps
module rasd_seq_model (
    input  wire       clk_sys_i, // Core clock
    output reg        push_o,    // Call or entry
    output reg  [9:0] pc_o,      // Pc to save
    output reg        sub_o,     // Subroutine return
    output reg        irq_o      // Interrupt return
);
// ****************
// Request driver
// ****************
initial begin
    push_o = 1'b0;
    pc_o   = 10'h000;
    sub_o  = 1'b0;
    irq_o  = 1'b0;
end
// pc beside push
// Requests hold until the next step call, so back-to-back calls need no gap
task step(input p, input s, input i, input [9:0] pc);
    begin
        push_o <= p;
        pc_o   <= pc;
        sub_o  <= s;
        irq_o  <= i;
        @(posedge clk_sys_i);
        #1;
    end
endtask
endmodule // rasd_seq_model

// ===== test/rasd_return_stack_sva.sv
/* Checker of the return-stack ports.
   Assumes one clock and an async active-low reset; bound onto the stack. */
`timescale 1ns/1ps
module rasd_return_stack_sva (
    input logic       clk_sys_i,             // Clock
    input logic       arst_n_i,              // Reset
    input logic       push_i,                // Push
    input logic [9:0] push_pc_i,             // Pc in
    input logic       ret_sub_i,             // Pop
    input logic       ret_irq_i,             // Pop
    input logic [9:0] pop_pc_o,              // Pc out
    input logic       pop_valid_o,           // Pc valid
    input logic [1:0] stack_level_pointer_o, // Pointer
    input logic       global_irq_enable_o,   // Enable
    input logic [7:0] reg_addr_i,            // Address
    input logic [7:0] reg_wdata_i,           // Data in
    input logic       reg_we_i,              // Write
    input logic       reg_re_i,              // Read
    input logic [7:0] reg_rdata_o            // Data out
);
// ****************
// Port relations
// ****************
default clocking cb @(posedge clk_sys_i); endclocking
default disable iff (!arst_n_i);
wire pop_w = (ret_sub_i | ret_irq_i) & ~push_i;
a_push_step: assert property (push_i |=> stack_level_pointer_o == $past(stack_level_pointer_o) - 2'h1)
    else $error("pointer did not step down on push");
a_pop_step: assert property (pop_w |=> stack_level_pointer_o == $past(stack_level_pointer_o) + 2'h1)
    else $error("pointer did not step up on pop");
a_pop_valid: assert property (pop_w |=> pop_valid_o)
    else $error("pop gave no valid pulse");
a_lifo_pair: assert property (push_i ##1 pop_w |=> pop_pc_o == $past(push_pc_i, 2))
    else $error("pop after push returned another pc");
a_ptr_hold: assert property (!push_i && !pop_w && !(reg_we_i && reg_addr_i == 8'hDF)
    |=> $stable(stack_level_pointer_o))
    else $error("pointer moved without cause");
a_rdata_idle: assert property (!reg_re_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
a_gie_write: assert property (reg_we_i && reg_addr_i == 8'hDF |=> global_irq_enable_o == $past(reg_wdata_i[7]))
    else $error("enable bit not written");
a_hi_unused: assert property (reg_re_i && reg_addr_i[7:3] == 5'h1E && reg_addr_i[0]
    |=> reg_rdata_o[7:2] == 6'h00)
    else $error("high slot unused bits not zero");
endmodule // rasd_return_stack_sva
bind rasd_return_stack rasd_return_stack_sva u_sva (.*);

// ===== test/rasd_return_stack_tb_top.sv
/* Bench of the return stack: register tasks, sequencer model, checks.
   Assumes the stack design and its checker bind are compiled first. */
`timescale 1ns/1ps
module rasd_return_stack_tb_top;
reg        clk_sys_i = 1'b0, arst_n_i = 1'b0, reg_we_i = 1'b0, reg_re_i = 1'b0;
reg  [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
wire       push_i, ret_sub_i, ret_irq_i, pop_valid_o, global_irq_enable_o;
wire [9:0] push_pc_i, pop_pc_o;
wire [1:0] stack_level_pointer_o;
wire [7:0] reg_rdata_o;
integer    error_cnt = 0, compares = 0, n;
reg  [9:0] pcs [0:4];
always #2 clk_sys_i = ~clk_sys_i;
rasd_seq_model u_seq (.clk_sys_i(clk_sys_i), .push_o(push_i), .pc_o(push_pc_i), .sub_o(ret_sub_i), .irq_o(ret_irq_i));
rasd_return_stack dut (.*);
// ****************
// Tasks
// ****************
task stop_test;
    begin
        $display("Counts: %0d compares, %0d errors", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    end
endtask
task cmp8(input [7:0] g, input [7:0] e);
    begin
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: register read %h, want %h", $time, g, e);
        end
    end
endtask
task cmp10(input [9:0] g, input [9:0] e);
    begin
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: stack port %h, want %h", $time, g, e);
        end
    end
endtask
task bus(input w, input r, input [7:0] a, input [7:0] d);
    begin
        reg_we_i    <= w;
        reg_re_i    <= r;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        #1;
    end
endtask
task wr(input [7:0] a, input [7:0] d);
    begin
        bus(1'b1, 1'b0, a, d);
        bus(1'b0, 1'b0, a, d);
    end
endtask
task rd(input [7:0] a, input [7:0] e);
    begin
        bus(1'b0, 1'b1, a, 8'h00);
        cmp8(reg_rdata_o, e);
        bus(1'b0, 1'b0, a, 8'h00);
        cmp8(reg_rdata_o, 8'h00);
    end
endtask
task psh(input [9:0] pc, input [1:0] pe);
    begin
        u_seq.step(1'b1, 1'b0, 1'b0, pc);
        cmp10({8'h00, stack_level_pointer_o}, {8'h00, pe});
    end
endtask
task pop(input s, input [9:0] e, input [1:0] pe);
    begin
        u_seq.step(1'b0, s, !s, 10'h000);
        cmp10(pop_pc_o, e);
        cmp10({7'h00, pop_valid_o, stack_level_pointer_o}, {7'h00, 1'b1, pe});
    end
endtask
// ****************
// Tests
// ****************
initial begin
    #20000;
    error_cnt++;
    stop_test;
end
initial begin
    pcs[0] = 10'h155; pcs[1] = 10'h2AA; pcs[2] = 10'h3FF; pcs[3] = 10'h001; pcs[4] = 10'h200;
    repeat (5) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    rd(8'hDF, 8'h03);
    for (n = 0; n < 9; n++) rd(8'hF0 + n[7:0], 8'h00);
    $display("Test reset values done");
    wr(8'hDF, 8'h03);
    for (n = 0; n < 5; n++) psh(pcs[n], 2'h2 - n[1:0]);
    u_seq.step(1'b0, 1'b0, 1'b0, 10'h000);
    for (n = 0; n < 4; n++) begin
        rd(8'hF0 + 2 * n[7:0], pcs[n == 0 ? 4 : n][7:0]);
        rd(8'hF1 + 2 * n[7:0], {6'h00, pcs[n == 0 ? 4 : n][9:8]});
    end
    for (n = 0; n < 4; n++) pop(n[0], pcs[n == 0 ? 4 : 4 - n], 2'h3 + n[1:0]);
    u_seq.step(1'b0, 1'b0, 1'b0, 10'h000);
    $display("Test push and pop done");
    wr(8'hDF, 8'h81);
    rd(8'hDF, 8'h81);
    cmp10({7'h00, global_irq_enable_o, stack_level_pointer_o}, 10'h005);
    wr(8'hF2, 8'hA5);
    wr(8'hF3, 8'hFE);
    rd(8'hF3, 8'h02);
    pop(1'b1, 10'h2A5, 2'h2);
    psh(10'h0F0, 2'h1);
    pop(1'b0, 10'h0F0, 2'h2);
    u_seq.step(1'b0, 1'b0, 1'b0, 10'h000);
    $display("Test registers done");
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    arst_n_i <= 1'b0;
    @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rd(8'hDF, 8'h03);
    rd(8'hF5, 8'h00);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    $display("Test second reset done");
    stop_test;
end
endmodule // rasd_return_stack_tb_top
